// ===== bench/motor_load.sv
// Purpose: behavioural motor and power stage behind the stop-mode sequencer
// Assumes: spin-down takes STOP_CYCLES clocks once torque is withdrawn
// Notes: an immediate stop keeps the drive enabled but still winds the motor down
`default_nettype none
module motor_load #(
  parameter int STOP_CYCLES = 20
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic drive_en_i,
  input wire logic imm_stop_i,
  output logic motor_stopped_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // spin-down counter
  // ----------------------------------------
  int cnt;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= 0;
    end else if (drive_en_i && !imm_stop_i) begin
      cnt <= STOP_CYCLES;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end
  end
  // standstill only after a full spin-down, never early
  assign motor_stopped_o = (cnt == 0);
endmodule
`default_nettype wire

// ===== bench/servo_stop_mode_sequencer_tb_top.sv
// Purpose: self-checking bench for the stop-mode sequencer
// Assumes: TICK_CYCLES cut to 10, so one hold step is 10 clocks
// Notes: every stop scenario starts from a fresh reset and power-up
`default_nettype none
`include "stop_mode_regs.svh"
module servo_stop_mode_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  localparam int TICK = 10;
  localparam logic [7:0] RA [10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h3C};
  localparam logic [31:0] RV [10] = '{32'h1, 32'h0, 32'h0, 32'h0, 32'h0, 32'h46, 32'h0, 32'h0, 32'h0, 32'h0};
  localparam logic [7:0] WA [8] = '{8'h00, 8'h08, 8'h08, 8'h0C, 8'h14, 8'h14, 8'h14, 8'h3C};
  localparam logic [31:0] WD [8] = '{32'h3, 32'hA, 32'h9, 32'hF, 32'h45, 32'h7D1, 32'h7D0, 32'hFFFFFFFF};
  localparam logic [31:0] WE [8] = '{32'h1, 32'h0, 32'h9, 32'h0, 32'h46, 32'h46, 32'h7D0, 32'h0};
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wr_data_i = 32'h0;
  logic wr_i = 1'b0, rd_i = 1'b0;
  logic fwd_prohibit_i = 1'b0, rev_prohibit_i = 1'b0, servo_on_i = 1'b0;
  logic main_power_ok_i = 1'b0, alarm_i = 1'b0, alarm_imm_ok_i = 1'b0;
  logic motor_stopped_i, drive_en_o, fwd_torque_en_o, rev_torque_en_o, dyn_brake_o, imm_stop_o;
  logic err_clear_o, undervoltage_trip_o, irq_o;
  logic [31:0] rd_data_o;
  int error_cnt = 0;
  int n_tests = 0;

  initial begin
    forever #50 mclk_i = ~mclk_i;
  end

  servo_stop_mode_sequencer #(.TICK_CYCLES(TICK)) dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .fwd_prohibit_i(fwd_prohibit_i),
    .rev_prohibit_i(rev_prohibit_i), .servo_on_i(servo_on_i), .main_power_ok_i(main_power_ok_i),
    .alarm_i(alarm_i), .alarm_imm_ok_i(alarm_imm_ok_i), .motor_stopped_i(motor_stopped_i),
    .drive_en_o(drive_en_o), .fwd_torque_en_o(fwd_torque_en_o), .rev_torque_en_o(rev_torque_en_o),
    .dyn_brake_o(dyn_brake_o), .imm_stop_o(imm_stop_o), .err_clear_o(err_clear_o),
    .undervoltage_trip_o(undervoltage_trip_o), .irq_o(irq_o));

  motor_load #(.STOP_CYCLES(20)) load (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .drive_en_i(drive_en_o),
    .imm_stop_i(imm_stop_o), .motor_stopped_o(motor_stopped_i));

  // ----------------------------------------
  // bus and check tasks
  // ----------------------------------------
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic timeout();
    error_cnt++;
    $display("wait limit used up at %0t ns", $time);
    end_sim();
  endtask

  // ends just after an edge, where registered outputs have settled
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wr_data_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    d = rd_data_o;
  endtask

  task automatic do_reset();
    @(posedge mclk_i);
    rst_n_i <= 1'b0;
    main_power_ok_i <= 1'b0;
    servo_on_i <= 1'b1;
    alarm_i <= 1'b0;
    alarm_imm_ok_i <= 1'b0;
    fwd_prohibit_i <= 1'b0;
    rev_prohibit_i <= 1'b0;
    repeat (8) @(posedge mclk_i);
    rst_n_i <= 1'b1;
  endtask

  // settings go in while mains is still off, since mains rising latches them
  task automatic power_up(input logic [1:0] psel, input logic [1:0] ssel, input logic [10:0] hold,
                          input logic uv);
    do_reset();
    wr(`OFS_PROHIBIT_INPUT, {30'h0, psel});
    wr(`OFS_PROHIBIT_STOP, {30'h0, ssel});
    wr(`OFS_HOLD_TIME, {21'h0, hold});
    wr(`OFS_UV_ACTION, {31'h0, uv});
    wr(`OFS_INT_MASK, 32'h7);
    @(posedge mclk_i);
    main_power_ok_i <= 1'b1;
    cyc(3);
    chk(drive_en_o, 1'b1);
  endtask

  task automatic run_stop(input int src, input logic [3:0] s);
    logic ok, imm, brk, afree, clr;
    int i;
    ok = (src == 2) && s[0];
    imm = (src == 2) ? (s[2] && ok) : s[3];
    brk = !imm && !s[0] && !(src == 2 && s == 4'h6);
    afree = (src != 2 && s[3]) ? s[0] : s[1];
    clr = (src == 2 || s[3]) ? 1'b1 : !s[2];
    power_up(2'h1, 2'h0, 11'h046, 1'b0);
    wr(`OFS_SERVO_OFF_STOP, {28'h0, src == 0 ? s : 4'h9 - s});
    wr(`OFS_POWER_OFF_STOP, {28'h0, src == 1 ? s : 4'h9 - s});
    wr(`OFS_ALARM_STOP, {29'h0, s[2:0]});
    @(posedge mclk_i);
    alarm_imm_ok_i <= ok;
    case (src)
      0: servo_on_i <= 1'b0;
      1: main_power_ok_i <= 1'b0;
      default: alarm_i <= 1'b1;
    endcase
    cyc(2);
    chk(drive_en_o, imm);
    chk(imm_stop_o, imm);
    chk(dyn_brake_o, brk);
    chk(err_clear_o, clr);
    for (i = 0; i < 200 && motor_stopped_i !== 1'b1; i++) cyc(1);
    if (i == 200) timeout();
    cyc(2);
    chk(dyn_brake_o, !afree);
    chk(drive_en_o, 1'b0);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    logic [31:0] d;
    logic ign;
    logic [1:0] s;
    int i;
    do_reset();
    for (i = 0; i < 10; i++) begin
      rd(RA[i], d);
      chk(d, RV[i]);
    end
    for (i = 0; i < 8; i++) begin
      wr(WA[i], WD[i]);
      rd(WA[i], d);
      chk(d, WE[i]);
    end
    // index 3 ignores the inputs; later writes must not undo the latched choice
    for (i = 0; i < 4; i++) begin
      ign = (i == 3);
      s = ign ? 2'h0 : i[1:0];
      power_up(ign ? 2'h1 : (i == 2 ? 2'h2 : 2'h0), s, 11'h046, 1'b0);
      wr(`OFS_PROHIBIT_INPUT, ign ? 32'h0 : 32'h1);
      @(posedge mclk_i);
      fwd_prohibit_i <= 1'b1;
      cyc(2);
      chk(fwd_torque_en_o, ign);
      chk(rev_torque_en_o, 1'b1);
      chk(dyn_brake_o, !ign && s == 2'h0);
      chk(imm_stop_o, !ign && s == 2'h2);
      chk(irq_o, !ign);
      @(posedge mclk_i);
      fwd_prohibit_i <= 1'b0;
      rev_prohibit_i <= 1'b1;
      cyc(2);
      chk(rev_torque_en_o, ign);
      chk(fwd_torque_en_o, 1'b1);
    end
    for (i = 0; i < 28; i++) begin
      run_stop(i / 10, 4'(i % 10));
    end
    // hold of 100 steps; a mains blip shorter than that must restart the count
    power_up(2'h1, 2'h0, 11'h064, 1'b0);
    wr(`OFS_HOLD_TIME, 32'h7D0);
    @(posedge mclk_i);
    main_power_ok_i <= 1'b0;
    cyc(600);
    chk(undervoltage_trip_o, 1'b0);
    @(posedge mclk_i);
    main_power_ok_i <= 1'b1;
    cyc(5);
    @(posedge mclk_i);
    main_power_ok_i <= 1'b0;
    for (i = 0; i < 3000 && undervoltage_trip_o !== 1'b1; i++) cyc(1);
    if (i == 3000) timeout();
    chk(i >= 985 && i <= 1015, 1'b1);
    chk(irq_o, 1'b1);
    rd(`OFS_INT_STATUS, d);
    chk(d, 32'h2);
    cyc(1);
    chk(irq_o, 1'b0);
    rd(`OFS_INT_STATUS, d);
    chk(d, 32'h0);
    // servo-off choice: no trip, and a masked event keeps the interrupt low
    power_up(2'h1, 2'h0, 11'h046, 1'b1);
    wr(`OFS_INT_MASK, 32'h0);
    @(posedge mclk_i);
    main_power_ok_i <= 1'b0;
    cyc(760);
    chk(undervoltage_trip_o, 1'b0);
    chk(irq_o, 1'b0);
    rd(`OFS_STATE, d);
    chk(d[2], 1'b1);
    rd(`OFS_INT_STATUS, d);
    chk(d, 32'h2);
    end_sim();
  end
endmodule
`default_nettype wire

// ===== logic/hold_timer.sv
// Purpose: momentary hold timer raising the main power supply alarm
// Assumes: power_ok_i synchronous to mclk_i
// Notes: 1 ms tick from the system clock
`default_nettype none
`include "stop_mode_regs.svh"
module hold_timer #(
  parameter int TICK_CYCLES = `HOLD_STEP_NS / `CLK_PERIOD_NS
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic power_ok_i,
  input wire logic [10:0] hold_ms_i,
  output logic alarm_o
);
  typedef struct packed {
    logic [15:0] tick_cnt;
    logic [10:0] ms_cnt;
    logic alarm;
  } timer_t;

  timer_t st_reg, st_next;

  // ----------------------------------------
  // counting
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    if (power_ok_i) begin
      st_next = '0;
    end else if (st_reg.tick_cnt == 16'(TICK_CYCLES - 1)) begin
      st_next.tick_cnt = 16'h0000;
      if (st_reg.ms_cnt != `MAX_HOLD_TIME) begin
        st_next.ms_cnt = st_reg.ms_cnt + 11'h001;
      end
    end else begin
      st_next.tick_cnt = st_reg.tick_cnt + 16'h0001;
    end
    if (!power_ok_i && st_reg.ms_cnt >= hold_ms_i) begin
      st_next.alarm = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign alarm_o = st_reg.alarm;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  restart_on_power_a: assert property (power_ok_i |=> !alarm_o && st_reg.ms_cnt == 11'h000)
    else $error("hold timer did not restart on power return");
  alarm_early_a: assert property ($rose(alarm_o) |-> $past(st_reg.ms_cnt) >= $past(hold_ms_i))
    else $error("mains alarm before hold time elapsed");
endmodule
`default_nettype wire

// ===== logic/servo_stop_mode_sequencer.sv
// Purpose: selects stop actions on prohibit, servo-off, main power loss and alarm
// Assumes: all inputs synchronous to mclk_i; single-cycle register strobes
// Notes: outputs are registered, so they follow inputs by one clock
`default_nettype none
`include "stop_mode_regs.svh"

// Overview of operation
// - selection 1 ignores both prohibit inputs
// - selection 0 or 2 obeys prohibit inputs
// - prohibit stop 0: torque off, dynamic brake
// - prohibit stop 1: torque off, free-run
// - prohibit stop 2: torque off, immediate stop
// - servo-off 0..7: bits pick decel, after, counter
// - servo-off 8/9: immediate stop, clear, brake/free
// - power-off stop uses same encoding separately
// - mains alarm trips undervoltage or servo-off
// - mains alarm after hold time in ms
// - alarm 0..3: bits pick decel and after
// - alarm 4..7: immediate stop first if allowed
module servo_stop_mode_sequencer import stop_mode_pkg::*; #(
  parameter int TICK_CYCLES = `HOLD_STEP_NS / `CLK_PERIOD_NS
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rd_data_o,
  input wire logic fwd_prohibit_i,
  input wire logic rev_prohibit_i,
  input wire logic servo_on_i,
  input wire logic main_power_ok_i,
  input wire logic alarm_i,
  input wire logic alarm_imm_ok_i,
  input wire logic motor_stopped_i,
  output logic drive_en_o,
  output logic fwd_torque_en_o,
  output logic rev_torque_en_o,
  output logic dyn_brake_o,
  output logic imm_stop_o,
  output logic err_clear_o,
  output logic undervoltage_trip_o,
  output logic irq_o
);
  typedef struct packed {
    logic [1:0] pis;
    logic [1:0] pss;
    logic [3:0] soff_sel;
    logic [3:0] poff_sel;
    logic uv_sel;
    logic [10:0] hold;
    logic [2:0] alm_sel;
    logic [1:0] act_pis;
    logic [1:0] act_pss;
    logic [10:0] act_hold;
    logic loaded;
    logic pwr_q;
    logic [`INT_WIDTH-1:0] status;
    logic [`INT_WIDTH-1:0] mask;
    logic [`INT_WIDTH-1:0] ev_q;
    phase_t phase;
    logic [31:0] rd_data;
    logic drive_en;
    logic fwd_en;
    logic rev_en;
    logic brake;
    logic imm;
    logic clr;
    logic uv_trip;
    logic irq;
  } state_t;

  state_t st_reg, st_next;
  logic mains_alarm;
  logic pro_en;
  logic stop_c;
  src_t src;
  action_t act;
  logic [`INT_WIDTH-1:0] ev;

  hold_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_hold (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .power_ok_i(main_power_ok_i),
    .hold_ms_i(st_reg.act_hold),
    .alarm_o(mains_alarm)
  );

  // ----------------------------------------
  // stop source and action
  // ----------------------------------------
  always_comb begin
    pro_en = (st_reg.act_pis != `RST_PROHIBIT_INPUT);
    src = SRC_NONE;
    act = decode_stop(st_reg.soff_sel);
    if (alarm_i || (mains_alarm && !st_reg.uv_sel)) begin
      src = SRC_ALARM;
      act.decel = st_reg.alm_sel[`BIT_DECEL_FREE] ? DEC_FREE : DEC_BRAKE;
      // value 6 coasts like 7, so bit 0 alone cannot pick its decel action
      if (st_reg.alm_sel == 3'h6) begin
        act.decel = DEC_FREE;
      end
      if (st_reg.alm_sel[`BIT_ALARM_IMM] && alarm_imm_ok_i) begin
        act.decel = DEC_IMM;
      end
      act.after_free = st_reg.alm_sel[`BIT_AFTER_FREE];
      act.clear_err = 1'b1;
    end else if (!main_power_ok_i) begin
      src = SRC_POWER;
      act = decode_stop(st_reg.poff_sel);
    end else if (!servo_on_i || mains_alarm) begin
      src = SRC_SOFF;
    end
    stop_c = (src != SRC_NONE);
    ev = '0;
    ev[`INT_PROHIBIT] = !stop_c && pro_en && (fwd_prohibit_i || rev_prohibit_i);
    ev[`INT_MAINS_ALARM] = mains_alarm;
    ev[`INT_ALARM] = alarm_i;
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    // latch prohibit and hold settings once at the first mains power-up so they never shift
    st_next.pwr_q = main_power_ok_i;
    if (!st_reg.loaded && main_power_ok_i && !st_reg.pwr_q) begin
      st_next.loaded = 1'b1;
      st_next.act_pis = st_reg.pis;
      st_next.act_pss = st_reg.pss;
      st_next.act_hold = st_reg.hold;
    end

    if (!stop_c) begin
      st_next.phase = PH_RUN;
    end else if (st_reg.phase == PH_RUN) begin
      st_next.phase = PH_DECEL;
    end else if (motor_stopped_i) begin
      st_next.phase = PH_HELD;
    end

    case (st_next.phase)
      PH_RUN: begin
        st_next.drive_en = 1'b1;
        st_next.fwd_en = !(pro_en && fwd_prohibit_i);
        st_next.rev_en = !(pro_en && rev_prohibit_i);
        st_next.brake = ev[`INT_PROHIBIT] && st_reg.act_pss == 2'h0;
        st_next.imm = ev[`INT_PROHIBIT] && st_reg.act_pss == `MAX_PROHIBIT_SEL;
        st_next.clr = 1'b0;
      end
      PH_DECEL: begin
        st_next.drive_en = (act.decel == DEC_IMM);
        st_next.fwd_en = (act.decel == DEC_IMM);
        st_next.rev_en = (act.decel == DEC_IMM);
        st_next.brake = (act.decel == DEC_BRAKE);
        st_next.imm = (act.decel == DEC_IMM);
        st_next.clr = act.clear_err;
      end
      PH_HELD: begin
        st_next.drive_en = 1'b0;
        st_next.fwd_en = 1'b0;
        st_next.rev_en = 1'b0;
        st_next.brake = !act.after_free;
        st_next.imm = 1'b0;
        st_next.clr = act.clear_err;
      end
      default: begin
        st_next.phase = PH_RUN;
      end
    endcase
    st_next.uv_trip = mains_alarm && !st_reg.uv_sel;

    // register writes; out-of-range values are refused and the old value kept
    if (wr_i) begin
      case (addr_i)
        `OFS_PROHIBIT_INPUT: if (wr_data_i[1:0] <= `MAX_PROHIBIT_SEL) st_next.pis = wr_data_i[1:0];
        `OFS_PROHIBIT_STOP: if (wr_data_i[1:0] <= `MAX_PROHIBIT_SEL) st_next.pss = wr_data_i[1:0];
        `OFS_SERVO_OFF_STOP: if (wr_data_i[3:0] <= `MAX_STOP_SEL) st_next.soff_sel = wr_data_i[3:0];
        `OFS_POWER_OFF_STOP: if (wr_data_i[3:0] <= `MAX_STOP_SEL) st_next.poff_sel = wr_data_i[3:0];
        `OFS_UV_ACTION: st_next.uv_sel = wr_data_i[0];
        `OFS_HOLD_TIME: begin
          if (wr_data_i[10:0] >= `MIN_HOLD_TIME && wr_data_i[10:0] <= `MAX_HOLD_TIME) begin
            st_next.hold = wr_data_i[10:0];
          end
        end
        `OFS_ALARM_STOP: st_next.alm_sel = wr_data_i[2:0];
        `OFS_INT_MASK: st_next.mask = wr_data_i[`INT_WIDTH-1:0];
        default: begin
        end
      endcase
    end

    // ----------------------------------------
    // interrupt status, read to clear; a new event beats the clear
    // ----------------------------------------
    st_next.ev_q = ev;
    if (rd_i && addr_i == `OFS_INT_STATUS) begin
      st_next.status = '0;
    end
    st_next.status = st_next.status | (ev & ~st_reg.ev_q);
    st_next.irq = |(st_next.status & st_next.mask);

    st_next.rd_data = 32'h0000_0000;
    if (rd_i) begin
      case (addr_i)
        `OFS_PROHIBIT_INPUT: st_next.rd_data[1:0] = st_reg.pis;
        `OFS_PROHIBIT_STOP: st_next.rd_data[1:0] = st_reg.pss;
        `OFS_SERVO_OFF_STOP: st_next.rd_data[3:0] = st_reg.soff_sel;
        `OFS_POWER_OFF_STOP: st_next.rd_data[3:0] = st_reg.poff_sel;
        `OFS_UV_ACTION: st_next.rd_data[0] = st_reg.uv_sel;
        `OFS_HOLD_TIME: st_next.rd_data[10:0] = st_reg.hold;
        `OFS_ALARM_STOP: st_next.rd_data[2:0] = st_reg.alm_sel;
        `OFS_INT_STATUS: st_next.rd_data[`INT_WIDTH-1:0] = st_reg.status;
        `OFS_INT_MASK: st_next.rd_data[`INT_WIDTH-1:0] = st_reg.mask;
        `OFS_STATE: st_next.rd_data[18:0] = {st_reg.act_hold, st_reg.act_pss, st_reg.act_pis,
                                             st_reg.loaded, mains_alarm, src};
        default: st_next.rd_data = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
      st_reg.pis <= `RST_PROHIBIT_INPUT;
      st_reg.pss <= `RST_PROHIBIT_STOP;
      st_reg.soff_sel <= `RST_STOP_SELECT;
      st_reg.poff_sel <= `RST_STOP_SELECT;
      st_reg.uv_sel <= `RST_UV_ACTION;
      st_reg.hold <= `RST_HOLD_TIME;
      st_reg.alm_sel <= `RST_ALARM_STOP;
      st_reg.act_pis <= `RST_PROHIBIT_INPUT;
      st_reg.act_pss <= `RST_PROHIBIT_STOP;
      st_reg.act_hold <= `RST_HOLD_TIME;
      st_reg.phase <= PH_RUN;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rd_data_o = st_reg.rd_data;
  assign drive_en_o = st_reg.drive_en;
  assign fwd_torque_en_o = st_reg.fwd_en;
  assign rev_torque_en_o = st_reg.rev_en;
  assign dyn_brake_o = st_reg.brake;
  assign imm_stop_o = st_reg.imm;
  assign err_clear_o = st_reg.clr;
  assign undervoltage_trip_o = st_reg.uv_trip;
  assign irq_o = st_reg.irq;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  prohibit_ignored_a: assert property (!stop_c && st_reg.act_pis == 2'h1 |=> fwd_torque_en_o && rev_torque_en_o)
    else $error("prohibit input not ignored");
  prohibit_obeyed_a: assert property (!stop_c && st_reg.act_pis != 2'h1 && fwd_prohibit_i |=> !fwd_torque_en_o)
    else $error("forward prohibit not obeyed");
  prohibit_brake_a: assert property (ev[0] && st_reg.act_pss == 2'h0 |=> dyn_brake_o && !imm_stop_o)
    else $error("prohibit stop 0 not braking");
  prohibit_coast_a: assert property (ev[0] && st_reg.act_pss == 2'h1 |=> !dyn_brake_o && !imm_stop_o)
    else $error("prohibit stop 1 not coasting");
  prohibit_imm_a: assert property (ev[0] && st_reg.act_pss == 2'h2 |=> imm_stop_o && !dyn_brake_o)
    else $error("prohibit stop 2 not immediate");
  soff_decel_a: assert property (src == SRC_SOFF && st_reg.phase == PH_RUN && st_reg.soff_sel < 4'h8
    |=> !drive_en_o && dyn_brake_o == !$past(st_reg.soff_sel[0]) && err_clear_o == !$past(st_reg.soff_sel[2]))
    else $error("servo-off decel action wrong");
  soff_imm_free_a: assert property (src == SRC_SOFF && st_reg.soff_sel == 4'h9 && st_reg.phase != PH_RUN
    && motor_stopped_i |=> !dyn_brake_o && !drive_en_o && err_clear_o)
    else $error("servo-off 9 after-stop wrong");
  poff_coast_a: assert property (src == SRC_POWER && st_reg.poff_sel == 4'h1 && st_reg.phase == PH_RUN
    |=> !dyn_brake_o && !drive_en_o ##1 (motor_stopped_i ? 1'b1 : !drive_en_o))
    else $error("power-off stop 1 wrong");
  uv_trip_a: assert property (mains_alarm && !st_reg.uv_sel |=> undervoltage_trip_o)
    else $error("undervoltage trip missing");
  uv_soff_a: assert property (mains_alarm && st_reg.uv_sel && !alarm_i |-> src != SRC_NONE ##1 !undervoltage_trip_o)
    else $error("undervoltage servo-off wrong");
  alarm_free_a: assert property (src == SRC_ALARM && st_reg.alm_sel == 3'h3 && st_reg.phase == PH_RUN
    |=> !dyn_brake_o && !imm_stop_o)
    else $error("alarm stop 3 decel wrong");
  alarm_imm_a: assert property (src == SRC_ALARM && st_reg.alm_sel[2] && alarm_imm_ok_i && st_reg.phase == PH_RUN
    |=> imm_stop_o && drive_en_o)
    else $error("alarm immediate stop missing");
  alarm_six_coast_a: assert property (src == SRC_ALARM && st_reg.alm_sel == 3'h6 && !alarm_imm_ok_i
    && st_reg.phase == PH_RUN
    |=> !dyn_brake_o && !imm_stop_o && !drive_en_o)
    else $error("alarm stop 6 not coasting");
  latched_stable_a: assert property (st_reg.loaded |=> $stable(st_reg.act_hold) && $stable(st_reg.act_pis))
    else $error("latched settings changed after power-up");

  prohibit_cov: cover property (ev[0] ##1 !fwd_torque_en_o);
  soff_stop_cov: cover property (src == SRC_SOFF ##1 st_reg.phase == PH_DECEL ##[1:20] st_reg.phase == PH_HELD);
  mains_alarm_cov: cover property ($rose(mains_alarm) ##1 undervoltage_trip_o);
  read_clear_cov: cover property (rd_i && addr_i == `OFS_INT_STATUS && st_reg.status != '0);
  alarm_imm_cov: cover property (src == SRC_ALARM ##1 imm_stop_o);
endmodule
`default_nettype wire

// ===== logic/stop_mode_pkg.sv
// Purpose: types shared by the stop-mode sequencer
// Assumes: nothing
// Notes: decode of the 0..9 stop selection lives here
`default_nettype none
package stop_mode_pkg;
  typedef enum logic [1:0] {DEC_BRAKE, DEC_FREE, DEC_IMM} decel_t;
  typedef enum logic [1:0] {PH_RUN, PH_DECEL, PH_HELD} phase_t;
  typedef enum logic [1:0] {SRC_NONE, SRC_ALARM, SRC_POWER, SRC_SOFF} src_t;

  typedef struct packed {
    decel_t decel;
    logic after_free;
    logic clear_err;
  } action_t;

  function automatic action_t decode_stop(input logic [3:0] sel);
    action_t a;
    a.decel = sel[0] ? DEC_FREE : DEC_BRAKE;
    a.after_free = sel[1];
    a.clear_err = ~sel[2];
    if (sel[3]) begin
      a.decel = DEC_IMM;
      a.after_free = sel[0];
      a.clear_err = 1'b1;
    end
    return a;
  endfunction
endpackage
`default_nettype wire

// ===== logic/stop_mode_regs.svh
// Purpose: offsets, field positions, reset values and timing for the stop-mode sequencer
// Assumes: 32-bit word registers at byte addresses, 10 MHz clock
// Notes: definitions only
`ifndef STOP_MODE_REGS_SVH
`define STOP_MODE_REGS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_PROHIBIT_INPUT 8'h00
`define OFS_PROHIBIT_STOP 8'h04
`define OFS_SERVO_OFF_STOP 8'h08
`define OFS_POWER_OFF_STOP 8'h0C
`define OFS_UV_ACTION 8'h10
`define OFS_HOLD_TIME 8'h14
`define OFS_ALARM_STOP 8'h18
`define OFS_INT_STATUS 8'h1C
`define OFS_INT_MASK 8'h20
`define OFS_STATE 8'h24

// ----------------------------------------
// reset values and limits
// ----------------------------------------
`define RST_PROHIBIT_INPUT 2'h1
`define RST_PROHIBIT_STOP 2'h0
`define RST_STOP_SELECT 4'h0
`define RST_UV_ACTION 1'h0
`define RST_HOLD_TIME 11'h046
`define RST_ALARM_STOP 3'h0
`define MAX_PROHIBIT_SEL 2'h2
`define MAX_STOP_SEL 4'h9
`define MIN_HOLD_TIME 11'h046
`define MAX_HOLD_TIME 11'h7D0

// ----------------------------------------
// field positions
// ----------------------------------------
`define BIT_DECEL_FREE 0
`define BIT_AFTER_FREE 1
`define BIT_HOLD_ERR 2
`define BIT_ALARM_IMM 2
`define INT_PROHIBIT 0
`define INT_MAINS_ALARM 1
`define INT_ALARM 2
`define INT_WIDTH 3

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS 100
`define HOLD_STEP_NS 1000000

`endif
